// ### pkg/wdog_pkg.sv
/*
 Shared constants and carriers for the windowed watchdog: register map,
 field positions, reset values, feed keys and timing figures.
 Assumes a 25 MHz system clock and an APB master with 32-bit data.
*/
package wdog_pkg;
   // system clock and watchdog tick rate
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned TICK_HZ_DEFAULT = 500000;
   localparam int unsigned TICK_DIV_DEFAULT = CLK_HZ / TICK_HZ_DEFAULT;
   localparam int CNT_W = 24;
   localparam int PRE_W = 2;
   localparam logic [PRE_W-1:0] PRE_LAST = 2'h3; // divide-by-four prescaler
   localparam logic [CNT_W-1:0] RELOAD_MIN = 24'h0000FF; // 256 steps of four ticks
   localparam logic [CNT_W-1:0] RELOAD_RST = 24'hFFFFFF;
   localparam logic [CNT_W-1:0] WINDOW_RST = 24'hFFFFFF; // window open by default
   localparam logic [CNT_W-1:0] WARN_RST = 24'h000000;
   localparam logic [3:0] RST_PULSE = 4'hF; // chip reset pulse, clock cycles

   // register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_RELOAD = 8'h04;
   localparam logic [7:0] OFS_FEED = 8'h08;
   localparam logic [7:0] OFS_COUNT = 8'h0C;
   localparam logic [7:0] OFS_WARN = 8'h10;
   localparam logic [7:0] OFS_WINDOW = 8'h14;
   localparam logic [7:0] OFS_INTSTAT = 8'h18;
   localparam logic [7:0] OFS_INTMASK = 8'h1C;

   // mode register bits
   localparam int MODE_EN = 0;
   localparam int MODE_RSTSEL = 1;
   localparam int MODE_RSTFLAG = 2;
   // interrupt status and mask bits
   localparam int INT_FAULT = 0;
   localparam int INT_WARN = 1;
   localparam int INT_W = 2;

   // feed keys, written back to back to the feed register
   localparam logic [7:0] FEED_KEY1 = 8'hAA;
   localparam logic [7:0] FEED_KEY2 = 8'h55;

   typedef enum logic [1:0] {
      FEED_IDLE = 2'h0,
      FEED_ARMED = 2'h1
   } feed_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
endpackage

// ### design/tick_divider.sv
/*
 Divider that stands in for the dedicated watchdog oscillator: one enable
 pulse every DIV system clocks. Assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
   parameter int unsigned DIV = 50
) (
   input wire logic clk,
   input wire logic rst_b,
   output logic tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } div_state_t;

   localparam logic [15:0] LAST = 16'(DIV - 1);

   div_state_t s;
   div_state_t next_s;

   // free-running count; the pulse is registered so it is glitch free
   always_comb begin
      next_s = s;
      next_s.tick = (s.cnt == LAST);
      next_s.cnt = (s.cnt == LAST) ? 16'h0000 : s.cnt + 16'h0001;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;
endmodule
`default_nettype wire

// ### design/windowed_watchdog.sv
/*
 Windowed watchdog with APB register access, divide-by-four prescaler,
 24-bit down-counter, warning interrupt, sticky enable and reset-or-interrupt
 fault action. Assumes rst_b is the power-on reset, and that the chip reset
 request drives the rest of the chip but not this block.
*/
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog
   import wdog_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_DIV_DEFAULT
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire wdog_pkg::apb_req_t apbReq,
   output wdog_pkg::apb_rsp_t apbRsp,
   output logic irq,
   output logic chipReset
);
   import wdog_pkg::*;

   typedef struct packed {
      logic enable;
      logic resetSel;
      logic resetFlag;
      logic [CNT_W-1:0] reload;
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] warnAt;
      logic [CNT_W-1:0] window;
      logic [PRE_W-1:0] pre;
      logic [INT_W-1:0] intStat;
      logic [INT_W-1:0] intMask;
      feed_t feed;
      logic [3:0] rstCnt;
      logic chipReset;
      logic irq;
      apb_rsp_t rsp;
   } wdog_state_t;

   wdog_state_t s;
   wdog_state_t next_s;
   logic tick;
   logic preTick;
   logic access;
   logic wrFeed;
   logic key2Write;
   logic feedOk;
   logic fault;

   // true for offsets that hold a register
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == OFS_MODE) || (a == OFS_RELOAD) || (a == OFS_FEED)
         || (a == OFS_COUNT) || (a == OFS_WARN) || (a == OFS_WINDOW)
         || (a == OFS_INTSTAT) || (a == OFS_INTMASK);
   endfunction

   // widen a 24-bit field onto the data bus
   function automatic logic [31:0] word24(input logic [CNT_W-1:0] v);
      word24 = {8'h00, v};
   endfunction

   // fixed-rate tick standing in for the watchdog oscillator
   tick_divider #(
      .DIV(TICK_DIV)
   ) u_tick (
      .clk(clk),
      .rst_b(rst_b),
      .tick(tick)
   );

   // decode of the current bus cycle; writes take effect in the access phase
   always_comb begin
      preTick = tick && (s.pre == PRE_LAST);
      access = apbReq.psel && apbReq.penable && s.rsp.pready;
      wrFeed = access && apbReq.pwrite && (apbReq.paddr == OFS_FEED);
      key2Write = wrFeed && (apbReq.pwdata[7:0] == FEED_KEY2);
   end

   // next state: bus slave, feed sequencer, counter and fault action
   always_comb begin
      next_s = s;
      feedOk = 1'b0;
      fault = 1'b0;

      // prescaler only runs while enabled so each period starts aligned
      if (s.enable && tick) begin
         next_s.pre = s.pre + 2'h1;
      end

      // slave answers with no wait state; read data latched in setup
      next_s.rsp.pready = apbReq.psel && !apbReq.penable;
      next_s.rsp.pslverr = apbReq.psel && !apbReq.penable && !isMapped(apbReq.paddr);
      next_s.rsp.prdata = 32'h00000000;
      if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
         unique case (apbReq.paddr)
            OFS_MODE: next_s.rsp.prdata = {29'h0, s.resetFlag, s.resetSel, s.enable};
            OFS_RELOAD: next_s.rsp.prdata = word24(s.reload);
            OFS_COUNT: next_s.rsp.prdata = word24(s.count);
            OFS_WARN: next_s.rsp.prdata = word24(s.warnAt);
            OFS_WINDOW: next_s.rsp.prdata = word24(s.window);
            OFS_INTSTAT: next_s.rsp.prdata = {30'h0, s.intStat};
            OFS_INTMASK: next_s.rsp.prdata = {30'h0, s.intMask};
            default: next_s.rsp.prdata = 32'h00000000;
         endcase
      end

      // software writes; clears come first so hardware sets below win
      if (access && apbReq.pwrite && !s.rsp.pslverr) begin
         unique case (apbReq.paddr)
            OFS_MODE: begin
               if (apbReq.pwdata[MODE_EN] && !s.enable) begin
                  next_s.enable = 1'b1;
                  next_s.count = s.reload;
                  next_s.pre = '0;
               end
               next_s.resetSel = s.resetSel | apbReq.pwdata[MODE_RSTSEL];
               if (apbReq.pwdata[MODE_RSTFLAG]) begin
                  next_s.resetFlag = 1'b0;
               end
            end
            // shortest period is 256 steps; smaller values are raised to it
            OFS_RELOAD: begin
               next_s.reload = (apbReq.pwdata[CNT_W-1:0] < RELOAD_MIN) ?
                  RELOAD_MIN : apbReq.pwdata[CNT_W-1:0];
            end
            OFS_WARN: next_s.warnAt = apbReq.pwdata[CNT_W-1:0];
            OFS_WINDOW: next_s.window = apbReq.pwdata[CNT_W-1:0];
            OFS_INTSTAT: next_s.intStat = s.intStat & ~apbReq.pwdata[INT_W-1:0];
            OFS_INTMASK: next_s.intMask = apbReq.pwdata[INT_W-1:0];
            default: begin
            end
         endcase
      end

      // feed sequencer: key1 arms, the very next access must be key2
      if (access) begin
         unique case (s.feed)
            FEED_IDLE: begin
               if (wrFeed && apbReq.pwdata[7:0] == FEED_KEY1) begin
                  next_s.feed = FEED_ARMED;
               end else if (wrFeed) begin
                  fault = s.enable;
               end
            end
            FEED_ARMED: begin
               next_s.feed = FEED_IDLE;
               if (!key2Write) begin
                  fault = s.enable;
               end else if (s.enable && s.count > s.window) begin
                  fault = 1'b1;
               end else begin
                  feedOk = 1'b1;
               end
            end
         endcase
      end

      // counter: reload on a good feed, else count prescaled ticks
      if (feedOk) begin
         next_s.count = s.reload;
         next_s.pre = '0;
      end else if (s.enable && preTick) begin
         if (s.count == '0) begin
            fault = 1'b1;
         end else begin
            next_s.count = s.count - 24'h000001;
         end
         if (s.count == s.warnAt) begin
            next_s.intStat[INT_WARN] = 1'b1;
         end
      end

      // fault action: disable, then reset request or sticky interrupt
      if (fault) begin
         next_s.enable = 1'b0;
         next_s.count = s.reload;
         next_s.feed = FEED_IDLE;
         if (s.resetSel) begin
            next_s.resetFlag = 1'b1;
            next_s.rstCnt = RST_PULSE;
         end else begin
            next_s.intStat[INT_FAULT] = 1'b1;
         end
      end else if (s.rstCnt != 4'h0) begin
         next_s.rstCnt = s.rstCnt - 4'h1;
      end

      // outputs registered from their next values
      next_s.chipReset = (next_s.rstCnt != 4'h0);
      next_s.irq = |(next_s.intStat & next_s.intMask);
   end

   // single state register; rst_b is power-on, so the reset flag survives chipReset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{enable: 1'b0, resetSel: 1'b0, resetFlag: 1'b0, reload: RELOAD_RST,
                count: RELOAD_RST, warnAt: WARN_RST, window: WINDOW_RST,
                pre: '0, intStat: '0, intMask: '0, feed: FEED_IDLE,
                rstCnt: 4'h0, chipReset: 1'b0, irq: 1'b0, rsp: '0};
      end else begin
         s <= next_s;
      end
   end

   assign apbRsp = s.rsp;
   assign irq = s.irq;
   assign chipReset = s.chipReset;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // expiry with reset selected raises the chip reset next cycle
   expiry_reset_a: assert property (
      s.enable && !feedOk && preTick && s.count == '0 && s.resetSel
      |=> chipReset && !s.enable)
      else $error("expiry did not request chip reset");

   // a feed above the window value disables and faults
   window_fault_a: assert property (
      s.enable && s.feed == FEED_ARMED && key2Write && s.count > s.window
      |=> !s.enable && (chipReset || s.intStat[INT_FAULT]))
      else $error("early feed not treated as fault");

   // warning flag follows the compare point
   warn_flag_a: assert property (
      s.enable && !feedOk && !fault && preTick && s.count == s.warnAt
      |=> s.intStat[INT_WARN])
      else $error("warning flag missed");

   // enable only drops through a watchdog event
   enable_sticky_a: assert property (
      s.enable && !fault |=> s.enable)
      else $error("enable cleared without watchdog event");

   // a wrong second access after key1 is a fault
   feed_error_a: assert property (
      s.enable && s.feed == FEED_ARMED && access && !key2Write
      |=> !s.enable && s.feed == FEED_IDLE)
      else $error("bad feed sequence not faulted");

   // reset request has the flag set as the pulse rises, and the pulse lasts at least nine cycles
   reset_flag_a: assert property (
      $rose(chipReset) |-> s.resetFlag ##1 chipReset[*8])
      else $error("reset flag or pulse length wrong");

   // count holds still between prescaled ticks unless fed or faulted
   prescale_step_a: assert property (
      s.enable && !preTick && !feedOk && !fault |=> $stable(s.count))
      else $error("counter moved without prescaled tick");

   // good feed loads the reload value
   feed_reload_a: assert property (
      feedOk |=> s.count == $past(s.reload) && s.pre == '0)
      else $error("feed did not reload counter");

   // interrupt mode never pulls chip reset and holds the flag
   int_mode_a: assert property (
      fault && !s.resetSel && s.rstCnt == 4'h0
      |=> s.intStat[INT_FAULT] && !chipReset)
      else $error("interrupt mode fault handled wrongly");
endmodule
`default_nettype wire

// ### sim/tb.sv
/*
 Self-checking bench for the windowed watchdog: APB master tasks, a small
 register model kept in integers, and scenarios for counting and faults.
 Assumes a zero-wait APB slave with registered outputs and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import wdog_pkg::*;
   // a short tick keeps one full period near 2k clocks
   localparam int unsigned DIV = 2;
   // clocks from enable with the shortest reload to a warning at 0x80
   localparam int WARN_CYC = (int'(RELOAD_MIN) - 128 + 1) * 4 * int'(DIV);
   logic clk;
   logic rst_b;
   apb_req_t req;
   apb_rsp_t rsp;
   logic irq;
   logic chipReset;
   int failures;
   int numChecks;
   int mdl [8];
   int n;
   logic [31:0] rd;
   logic err;
   logic [15:0] lfsr;

   windowed_watchdog #(.TICK_DIV(DIV)) u_windowed_watchdog (
      .clk(clk),
      .rst_b(rst_b),
      .apbReq(req),
      .apbRsp(rsp),
      .irq(irq),
      .chipReset(chipReset)
   );

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // hang guard, well past the expected run of about 6k clocks
   initial begin
      #(40 * 40000);
      failures++;
      report_and_stop();
   end

   function automatic logic [15:0] lfsr_step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic report_and_stop();
      if (failures == 0 && numChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // pins are registered: let two edges land before looking
   task automatic chk_pin(input logic rstPin, input logic exp);
      repeat (2) @(posedge clk);
      chk({31'h0, rstPin ? chipReset : irq}, {31'h0, exp});
   endtask

   // one APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge clk);
      req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (rsp.pready !== 1'b1 && k < 16);
      chk({31'h0, k < 16}, 32'h1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   // write and track the plain configuration registers in the model
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a == OFS_RELOAD) begin
         mdl[1] = (d[23:0] < 24'hFF) ? 32'hFF : {8'h0, d[23:0]};
      end
      if (a == OFS_WARN || a == OFS_WINDOW) begin
         mdl[a[4:2]] = {8'h0, d[23:0]};
      end
      if (a == OFS_INTMASK) begin
         mdl[7] = {30'h0, d[1:0]};
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic wait_pin(input logic rstPin, input int lim);
      int k;
      k = 0;
      while ((rstPin ? chipReset : irq) !== 1'b1 && k < lim) begin
         @(posedge clk);
         k++;
      end
      n = k;
      chk({31'h0, k < lim}, 32'h1);
   endtask

   task automatic feed(input logic [7:0] key2);
      wr(OFS_FEED, {24'h0, FEED_KEY1});
      wr(OFS_FEED, {24'h0, key2});
   endtask

   // main sequence
   initial begin
      rst_b = 1'b0;
      req = '0;
      failures = 0;
      numChecks = 0;
      lfsr = 16'hF473;
      mdl = '{0, 'hFFFFFF, 0, 'hFFFFFF, 0, 'hFFFFFF, 0, 0};
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (i != 2) begin
            rd_chk(8'(i * 4), mdl[i]);
         end
      end
      apb(1'b1, 8'h20, 32'hFFFFFFFF);
      apb(1'b0, 8'h20, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      repeat (4) begin
         lfsr = lfsr_step(lfsr);
         wr(OFS_WARN, {lfsr, lfsr});
         rd_chk(OFS_WARN, mdl[4]);
         wr(OFS_INTMASK, {16'h0, lfsr});
         rd_chk(OFS_INTMASK, mdl[7]);
      end
      wr(OFS_RELOAD, 32'h10);
      rd_chk(OFS_RELOAD, mdl[1]);
      // interrupt mode: warning first, then expiry
      wr(OFS_INTMASK, 32'h3);
      wr(OFS_WARN, 32'h80);
      wr(OFS_MODE, 32'h1);
      wr(OFS_MODE, 32'h0);
      rd_chk(OFS_MODE, 32'h1);
      wait_pin(1'b0, 3000);
      // six clocks of bus traffic lie between the enable landing and the wait
      chk({31'h0, n + 6 >= WARN_CYC - 2 && n + 6 <= WARN_CYC + 2}, 32'h1);
      rd_chk(OFS_INTSTAT, 32'h2);
      wr(OFS_INTSTAT, 32'h2);
      chk_pin(1'b0, 1'b0);
      wait_pin(1'b0, 3000);
      rd_chk(OFS_INTSTAT, 32'h1);
      rd_chk(OFS_MODE, 32'h0);
      chk_pin(1'b1, 1'b0);
      chk_pin(1'b0, 1'b1);
      wr(OFS_INTSTAT, 32'h1);
      chk_pin(1'b0, 1'b0);
      // a good feed reloads the count without a fault
      wr(OFS_WARN, 32'h0);
      wr(OFS_MODE, 32'h1);
      repeat (400) @(posedge clk);
      feed(FEED_KEY2);
      apb(1'b0, OFS_COUNT, 32'h0);
      chk({31'h0, rd >= 32'hFE && rd <= 32'hFF}, 32'h1);
      rd_chk(OFS_INTSTAT, 32'h0);
      // wrong second key, then a read between the keys
      for (int v = 0; v < 2; v++) begin
         wr(OFS_MODE, 32'h1);
         wr(OFS_FEED, {24'h0, FEED_KEY1});
         if (v == 0) begin
            wr(OFS_FEED, 32'h12);
         end else begin
            apb(1'b0, OFS_COUNT, 32'h0);
         end
         rd_chk(OFS_INTSTAT, 32'h1);
         wr(OFS_INTSTAT, 32'h1);
      end
      // while disabled a stray feed write is ignored
      wr(OFS_FEED, 32'h12);
      rd_chk(OFS_INTSTAT, 32'h0);
      // window: too early is a fault, inside the window is a service
      wr(OFS_WINDOW, 32'h40);
      rd_chk(OFS_WINDOW, mdl[5]);
      wr(OFS_MODE, 32'h1);
      feed(FEED_KEY2);
      rd_chk(OFS_INTSTAT, 32'h1);
      wr(OFS_INTSTAT, 32'h1);
      wr(OFS_MODE, 32'h1);
      repeat (1600) @(posedge clk);
      feed(FEED_KEY2);
      rd_chk(OFS_INTSTAT, 32'h0);
      // reset mode: expiry gives a chip reset pulse and the flag
      wr(OFS_MODE, 32'h3);
      wait_pin(1'b1, 3000);
      n = 0;
      while (chipReset === 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n), 32'(RST_PULSE));
      rd_chk(OFS_MODE, 32'h6);
      wr(OFS_MODE, 32'h4);
      rd_chk(OFS_MODE, 32'h2);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd_chk(OFS_MODE, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
